// >>> pkg/rtc_regs.svh
// What this block does
// [R1] Sign bit 0 slows the prescaler by skipping; 1 speeds it by double steps.
// [R2] Software sets prescaler to divide by two or more before negative correction.
// [R3] Seven-bit amount gives that many correction clocks per million timekeeping ticks.
// [R4] Two-bit source choice picks fast internal, slow internal, crystal or external pin.
// [R5] Software enables and configures the crystal oscillator before choosing it.
// [R6] Counter is a low byte and a high byte, both readable and writable.
// [R7] Counter and wrap-limit writes take effect two timekeeping ticks later.
// [R8] Software waits for count sync pending clear before writing the counter.
// [R9] Software waits for wrap sync pending clear before writing the wrap limit.
// [R10] Wrap limit is two bytes and resets to all ones.
// [R11] Match value is two bytes and resets to zero.
// [R12] Interval code 0 is off, 1 to 14 give 4 to 32768 ticks, 15 reserved.
// [R13] Writing one to interval timer control bit 0 starts the interval timer.
// [R14] Interval sync pending stays high while a control write is crossing over.
// [R15] Interval irq enable bit 0 gates the periodic request.
// [R16] Periodic flag sets on each periodic event; writing one clears it.
// [R17] Drift correction applies only while the drift fix enable bit is set.
// [R18] Counter wraps to zero at the wrap limit and sets a write-one-clear flag.
// [R19] Counter equal to match value sets a write-one-clear compare flag.
// [R20] Prescaler field divides the timekeeping ticks by two to its power.
// [R21] Periodic irq output is high while flag and enable are both set.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

`define RTC_IDX_CTRL       5'h00
`define RTC_IDX_STATUS     5'h01
`define RTC_IDX_FLAGS      5'h03
`define RTC_IDX_CRYSTAL_CALIBRATION      5'h06
`define RTC_IDX_SRC        5'h07
`define RTC_IDX_CNT_L      5'h08
`define RTC_IDX_CNT_H      5'h09
`define RTC_IDX_PER_L      5'h0a
`define RTC_IDX_PER_H      5'h0b
`define RTC_IDX_CMP_L      5'h0c
`define RTC_IDX_CMP_H      5'h0d
`define RTC_IDX_PIT_CTRL   5'h10
`define RTC_IDX_PIT_STAT   5'h11
`define RTC_IDX_PIT_IEN    5'h12
`define RTC_IDX_PIT_FLAG   5'h13

`define RTC_CTRL_EN_BIT    0
`define RTC_CTRL_CORR_BIT  2
`define RTC_CTRL_PSC_LSB   3
`define RTC_STAT_CNT_BIT   1
`define RTC_STAT_PER_BIT   2
`define RTC_FLAG_WRAP_BIT  0
`define RTC_FLAG_CMP_BIT   1
`define RTC_CRYSTAL_CALIBRATION_SIGN_BIT 7
`define RTC_PIT_EN_BIT     0
`define RTC_PIT_PER_LSB    3
`define RTC_PIT_BUSY_BIT   0
`define RTC_PIT_IRQ_BIT    0
`define RTC_PIT_RESERVED   4'hf

`define RTC_BYTE_RST       8'h00
`define RTC_CNT_RST        16'h0000
`define RTC_PER_RST        16'hffff
`define RTC_CMP_RST        16'h0000
`define RTC_CORR_WINDOW    1000000
`define RTC_CORR_SLOT_BITS 12

`endif

// >>> pkg/rtc_pkg.sv
package rtc_pkg;
    typedef enum logic [1:0] {
        internal_fast_source,
        internal_slow_source,
        crystal_source,
        external_pin_source
    } source_choice_t;

    typedef enum logic [1:0] {
        sync_idle,
        sync_first,
        sync_second
    } sync_state_t;
endpackage : rtc_pkg

// >>> core/rtc_sync_stage.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_sync_stage #(
    parameter int W = 16
) (
    input  wire logic             i_mclk,
    input  wire logic             i_arst_n,
    input  wire logic             i_wr,
    input  wire logic [W-1:0]     i_wdata,
    input  wire logic [W/8-1:0]   i_wmask,
    input  wire logic             i_tick,
    output logic                  o_busy,
    output logic                  o_apply,
    output logic [W-1:0]          o_data,
    output logic [W/8-1:0]        o_mask
);
    rtc_pkg::sync_state_t st_q, st_d;
    logic [W-1:0]         data_q, data_d;
    logic [W/8-1:0]       mask_q, mask_d;
    logic [1:0]           seen_q, seen_d;

    always_comb begin
        st_d   = st_q;
        data_d = data_q;
        mask_d = mask_q;
        seen_d = seen_q;
        // Ticks counted since the last write, for the latency check
        if (i_tick && st_q != rtc_pkg::sync_idle && seen_q != 2'h3) seen_d = seen_q + 2'h1;
        case (st_q)
            rtc_pkg::sync_idle: st_d = rtc_pkg::sync_idle;
            rtc_pkg::sync_first: begin
                if (i_tick) st_d = rtc_pkg::sync_second;
            end
            rtc_pkg::sync_second: begin
                if (i_tick) st_d = rtc_pkg::sync_idle; // R7
            end
            default: st_d = rtc_pkg::sync_idle;
        endcase
        if (i_wr) begin
            st_d   = rtc_pkg::sync_first;
            seen_d = 2'h0;
            mask_d = (st_q == rtc_pkg::sync_idle || o_apply) ? i_wmask : (mask_q | i_wmask);
            for (int b = 0; b < W/8; b++) begin
                if (i_wmask[b]) data_d[b*8 +: 8] = i_wdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q   <= rtc_pkg::sync_idle;
            data_q <= '0;
            mask_q <= '0;
            seen_q <= 2'h0;
        end else begin
            st_q   <= st_d;
            data_q <= data_d;
            mask_q <= mask_d;
            seen_q <= seen_d;
        end
    end

    // Load strobe at the second timekeeping tick after the write
    assign o_apply = (st_q == rtc_pkg::sync_second) && i_tick; // R7
    assign o_busy  = (st_q != rtc_pkg::sync_idle); // R14
    assign o_data  = data_q;
    assign o_mask  = mask_q;

    property p_busy_after_write;
        @(posedge i_mclk) disable iff (!i_arst_n) i_wr |=> o_busy && !o_apply;
    endproperty
    a_busy_after_write: assert property (p_busy_after_write) else $error("sync busy not raised by write"); // R14

    property p_apply_two_ticks;
        @(posedge i_mclk) disable iff (!i_arst_n) o_apply |-> seen_q == 2'h1;
    endproperty
    a_apply_two_ticks: assert property (p_apply_two_ticks) else $error("applied before second tick"); // R7
endmodule : rtc_sync_stage
`default_nettype wire

// >>> core/rtc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_prescaler #(
    parameter int CORR_WINDOW = `RTC_CORR_WINDOW
) (
    input  wire logic       i_mclk,
    input  wire logic       i_arst_n,
    input  wire logic       i_tick,
    input  wire logic       i_enable,
    input  wire logic [3:0] i_div_exp,
    input  wire logic       i_corr_on,
    input  wire logic       i_corr_faster,
    input  wire logic [6:0] i_corr_amount,
    output logic            o_count_tick
);
    logic [19:0] win_q, win_d;
    logic [6:0]  done_q, done_d;
    logic [14:0] psc_q, psc_d;
    logic        slot;
    logic [1:0]  step;
    logic [15:0] sum;

    // Correction slots are spread over the window, one per 4096 ticks
    assign slot = i_corr_on && (done_q < i_corr_amount)
                  && (win_q[`RTC_CORR_SLOT_BITS-1:0] == '0); // R3 R17
    assign step = !slot ? 2'd1 : (i_corr_faster ? 2'd2 : 2'd0); // R1
    assign sum  = {1'b0, psc_q} + {14'h0, step};
    assign o_count_tick = i_tick && i_enable && ((sum >> i_div_exp) != ({1'b0, psc_q} >> i_div_exp)); // R20

    always_comb begin
        win_d  = win_q;
        done_d = done_q;
        psc_d  = psc_q;
        if (i_tick && i_enable) begin
            psc_d = sum[14:0];
            if (win_q == 20'(CORR_WINDOW - 1)) begin
                win_d  = '0;
                done_d = '0; // R3
            end else begin
                win_d  = win_q + 20'h1;
                done_d = done_q + {6'h0, slot};
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            win_q  <= '0;
            done_q <= '0;
            psc_q  <= '0;
        end else begin
            win_q  <= win_d;
            done_q <= done_d;
            psc_q  <= psc_d;
        end
    end

    property p_slow_skip;
        @(posedge i_mclk) disable iff (!i_arst_n)
            (i_tick && i_enable && slot && !i_corr_faster) |-> !o_count_tick;
    endproperty
    a_slow_skip: assert property (p_slow_skip) else $error("positive correction did not skip"); // R1

    property p_no_corr_div1;
        @(posedge i_mclk) disable iff (!i_arst_n)
            (i_tick && i_enable && !i_corr_on && i_div_exp == 4'h0) |-> o_count_tick;
    endproperty
    a_no_corr_div1: assert property (p_no_corr_div1) else $error("tick lost without correction"); // R17
endmodule : rtc_prescaler
`default_nettype wire

// >>> core/rtc_top.sv
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
module rtc_top #(
    parameter int CORR_WINDOW = `RTC_CORR_WINDOW
) (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic [6:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_internal_fast_tick,
    input  wire logic        i_internal_slow_tick,
    input  wire logic        i_crystal_tick,
    input  wire logic        i_external_pin_tick,
    output logic             o_periodic_tick_irq
);
    // Bus slave: one wait cycle per access, read data registered
    logic        ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic        req;
    logic        wr_go;
    logic [4:0]  idx;
    logic [7:0]  wd;
    logic [7:0]  rd_mux;

    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_q;
    assign wr_go             = i_avs_write & ack_q & i_avs_byteenable[0];
    assign idx               = i_avs_address[6:2];
    assign wd                = i_avs_writedata[7:0];
    assign o_avs_readdata    = rdata_q;

    // Software-visible registers
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  crystal_calibration_q, crystal_calibration_d;
    logic [1:0]  src_q, src_d;
    logic [15:0] per_sw_q, per_sw_d;
    logic [15:0] cmp_q, cmp_d;
    logic [7:0]  pit_sw_q, pit_sw_d;
    logic        pit_ien_q, pit_ien_d;
    logic        pit_flag_q, pit_flag_d;
    logic        wrap_flag_q, wrap_flag_d;
    logic        cmp_flag_q, cmp_flag_d;

    // Timekeeping state
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] per_q, per_d;
    logic [7:0]  pit_live_q, pit_live_d;
    logic [14:0] pit_cnt_q, pit_cnt_d;

    logic        tk_tick;
    logic        count_tick;
    logic        cnt_wr, per_wr, pit_wr;
    logic [1:0]  byte_sel;
    logic        cnt_busy, per_busy, pit_busy;
    logic        cnt_apply, per_apply, pit_apply;
    logic [15:0] cnt_sdata, per_sdata;
    logic [1:0]  cnt_smask, per_smask;
    logic [7:0]  pit_sdata;
    logic        pit_smask;
    logic [15:0] cnt_next;
    logic        wrap_set, cmp_set;
    logic [3:0]  pit_code;
    logic [15:0] pit_mask;
    logic [14:0] pit_inc;
    logic        pit_on;
    logic        pit_event;

    always_comb begin
        case (rtc_pkg::source_choice_t'(src_q))
            rtc_pkg::internal_fast_source: tk_tick = i_internal_fast_tick; // R4
            rtc_pkg::internal_slow_source: tk_tick = i_internal_slow_tick; // R4
            rtc_pkg::crystal_source:       tk_tick = i_crystal_tick; // R4
            rtc_pkg::external_pin_source:  tk_tick = i_external_pin_tick; // R4
            default:                       tk_tick = 1'b0;
        endcase
    end

    rtc_prescaler #(
        .CORR_WINDOW (CORR_WINDOW)
    ) u_prescaler (
        .i_mclk        (i_mclk),
        .i_arst_n      (i_arst_n),
        .i_tick        (tk_tick),
        .i_enable      (ctrl_q[`RTC_CTRL_EN_BIT]),
        .i_div_exp     (ctrl_q[`RTC_CTRL_PSC_LSB +: 4]),
        .i_corr_on     (ctrl_q[`RTC_CTRL_CORR_BIT]),
        .i_corr_faster (crystal_calibration_q[`RTC_CRYSTAL_CALIBRATION_SIGN_BIT]),
        .i_corr_amount (crystal_calibration_q[6:0]),
        .o_count_tick  (count_tick)
    );

    assign byte_sel = {idx[0], ~idx[0]};
    assign cnt_wr   = wr_go && (idx == `RTC_IDX_CNT_L || idx == `RTC_IDX_CNT_H); // R6
    assign per_wr   = wr_go && (idx == `RTC_IDX_PER_L || idx == `RTC_IDX_PER_H); // R10
    assign pit_wr   = wr_go && (idx == `RTC_IDX_PIT_CTRL);

    rtc_sync_stage #(.W(16)) u_cnt_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_wr     (cnt_wr),
        .i_wdata  ({wd, wd}),
        .i_wmask  (byte_sel),
        .i_tick   (tk_tick),
        .o_busy   (cnt_busy),
        .o_apply  (cnt_apply),
        .o_data   (cnt_sdata),
        .o_mask   (cnt_smask)
    );

    rtc_sync_stage #(.W(16)) u_per_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_wr     (per_wr),
        .i_wdata  ({wd, wd}),
        .i_wmask  (byte_sel),
        .i_tick   (tk_tick),
        .o_busy   (per_busy),
        .o_apply  (per_apply),
        .o_data   (per_sdata),
        .o_mask   (per_smask)
    );

    rtc_sync_stage #(.W(8)) u_pit_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_wr     (pit_wr),
        .i_wdata  (wd),
        .i_wmask  (1'b1),
        .i_tick   (tk_tick),
        .o_busy   (pit_busy),
        .o_apply  (pit_apply),
        .o_data   (pit_sdata),
        .o_mask   (pit_smask)
    );

    // Counter, wrap and compare
    assign cnt_next = (cnt_q == per_q) ? 16'h0000 : cnt_q + 16'h0001; // R18
    assign wrap_set = count_tick && !cnt_apply && (cnt_q == per_q); // R18
    assign cmp_set  = count_tick && !cnt_apply && (cnt_next == cmp_q); // R19

    always_comb begin
        cnt_d = cnt_q;
        per_d = per_q;
        if (cnt_apply) begin
            for (int b = 0; b < 2; b++) begin
                if (cnt_smask[b]) cnt_d[b*8 +: 8] = cnt_sdata[b*8 +: 8]; // R7
            end
        end else if (count_tick) begin
            cnt_d = cnt_next;
        end
        if (per_apply) begin
            for (int b = 0; b < 2; b++) begin
                if (per_smask[b]) per_d[b*8 +: 8] = per_sdata[b*8 +: 8]; // R7
            end
        end
    end

    // Interval timer on raw timekeeping ticks
    assign pit_code  = pit_live_q[`RTC_PIT_PER_LSB +: 4];
    assign pit_on    = pit_live_q[`RTC_PIT_EN_BIT]; // R13
    assign pit_mask  = 16'(16'h0002 << pit_code) - 16'h0001; // R12
    assign pit_inc   = pit_cnt_q + 15'h0001;
    assign pit_event = tk_tick && pit_on && pit_code != 4'h0 && pit_code != `RTC_PIT_RESERVED
                       && (({1'b0, pit_inc} & pit_mask) == 16'h0000); // R12

    always_comb begin
        pit_live_d = pit_live_q;
        pit_cnt_d  = pit_cnt_q;
        if (pit_smask && pit_apply) pit_live_d = pit_sdata; // R13
        if (!pit_on) pit_cnt_d = '0;
        else if (tk_tick) pit_cnt_d = pit_inc;
    end

    // Register writes; hardware set wins over a write-one clear
    always_comb begin
        ctrl_d      = ctrl_q;
        crystal_calibration_d     = crystal_calibration_q;
        src_d       = src_q;
        per_sw_d    = per_sw_q;
        cmp_d       = cmp_q;
        pit_sw_d    = pit_sw_q;
        pit_ien_d   = pit_ien_q;
        wrap_flag_d = wrap_flag_q;
        cmp_flag_d  = cmp_flag_q;
        pit_flag_d  = pit_flag_q;
        if (wr_go) begin
            case (idx)
                `RTC_IDX_CTRL:     ctrl_d = {1'b0, wd[6:2], 1'b0, wd[0]};
                `RTC_IDX_FLAGS: begin
                    if (wd[`RTC_FLAG_WRAP_BIT]) wrap_flag_d = 1'b0; // R18
                    if (wd[`RTC_FLAG_CMP_BIT])  cmp_flag_d  = 1'b0; // R19
                end
                `RTC_IDX_CRYSTAL_CALIBRATION:    crystal_calibration_d = wd;
                `RTC_IDX_SRC:      src_d = wd[1:0]; // R4
                `RTC_IDX_PER_L:    per_sw_d[7:0] = wd;
                `RTC_IDX_PER_H:    per_sw_d[15:8] = wd;
                `RTC_IDX_CMP_L:    cmp_d[7:0] = wd; // R11
                `RTC_IDX_CMP_H:    cmp_d[15:8] = wd; // R11
                `RTC_IDX_PIT_CTRL: pit_sw_d = {1'b0, wd[6:3], 2'b00, wd[0]};
                `RTC_IDX_PIT_IEN:  pit_ien_d = wd[`RTC_PIT_IRQ_BIT]; // R15
                `RTC_IDX_PIT_FLAG: begin
                    if (wd[`RTC_PIT_IRQ_BIT]) pit_flag_d = 1'b0; // R16
                end
                default: ctrl_d = ctrl_q;
            endcase
        end
        if (wrap_set)  wrap_flag_d = 1'b1; // R18
        if (cmp_set)   cmp_flag_d  = 1'b1; // R19
        if (pit_event) pit_flag_d  = 1'b1; // R16
    end

    always_comb begin
        case (idx)
            `RTC_IDX_CTRL:     rd_mux = ctrl_q;
            `RTC_IDX_STATUS:   rd_mux = {5'h00, per_busy, cnt_busy, 1'b0}; // R8 R9
            `RTC_IDX_FLAGS:    rd_mux = {6'h00, cmp_flag_q, wrap_flag_q};
            `RTC_IDX_CRYSTAL_CALIBRATION:    rd_mux = crystal_calibration_q;
            `RTC_IDX_SRC:      rd_mux = {6'h00, src_q};
            `RTC_IDX_CNT_L:    rd_mux = cnt_q[7:0]; // R6
            `RTC_IDX_CNT_H:    rd_mux = cnt_q[15:8]; // R6
            `RTC_IDX_PER_L:    rd_mux = per_sw_q[7:0];
            `RTC_IDX_PER_H:    rd_mux = per_sw_q[15:8];
            `RTC_IDX_CMP_L:    rd_mux = cmp_q[7:0];
            `RTC_IDX_CMP_H:    rd_mux = cmp_q[15:8];
            `RTC_IDX_PIT_CTRL: rd_mux = pit_sw_q;
            `RTC_IDX_PIT_STAT: rd_mux = {7'h00, pit_busy}; // R14
            `RTC_IDX_PIT_IEN:  rd_mux = {7'h00, pit_ien_q};
            `RTC_IDX_PIT_FLAG: rd_mux = {7'h00, pit_flag_q};
            default:           rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        ack_d   = req & ~ack_q;
        rdata_d = rdata_q;
        if (i_avs_read && !ack_q) rdata_d = {24'h000000, rd_mux};
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q       <= 1'b0;
            rdata_q     <= 32'h00000000;
            ctrl_q      <= `RTC_BYTE_RST;
            crystal_calibration_q     <= `RTC_BYTE_RST;
            src_q       <= 2'h0;
            per_sw_q    <= `RTC_PER_RST; // R10
            cmp_q       <= `RTC_CMP_RST; // R11
            pit_sw_q    <= `RTC_BYTE_RST;
            pit_ien_q   <= 1'b0;
            wrap_flag_q <= 1'b0;
            cmp_flag_q  <= 1'b0;
            pit_flag_q  <= 1'b0;
            cnt_q       <= `RTC_CNT_RST;
            per_q       <= `RTC_PER_RST; // R10
            pit_live_q  <= `RTC_BYTE_RST;
            pit_cnt_q   <= 15'h0000;
        end else begin
            ack_q       <= ack_d;
            rdata_q     <= rdata_d;
            ctrl_q      <= ctrl_d;
            crystal_calibration_q     <= crystal_calibration_d;
            src_q       <= src_d;
            per_sw_q    <= per_sw_d;
            cmp_q       <= cmp_d;
            pit_sw_q    <= pit_sw_d;
            pit_ien_q   <= pit_ien_d;
            wrap_flag_q <= wrap_flag_d;
            cmp_flag_q  <= cmp_flag_d;
            pit_flag_q  <= pit_flag_d;
            cnt_q       <= cnt_d;
            per_q       <= per_d;
            pit_live_q  <= pit_live_d;
            pit_cnt_q   <= pit_cnt_d;
        end
    end

    assign o_periodic_tick_irq = pit_flag_q & pit_ien_q; // R21

    property p_wrap_to_zero;
        @(posedge i_mclk) disable iff (!i_arst_n) wrap_set |=> (cnt_q == 16'h0000) && wrap_flag_q;
    endproperty
    a_wrap_to_zero: assert property (p_wrap_to_zero) else $error("counter did not wrap to zero"); // R18

    property p_compare_flag;
        @(posedge i_mclk) disable iff (!i_arst_n) cmp_set |=> cmp_flag_q && (cnt_q == $past(cmp_q));
    endproperty
    a_compare_flag: assert property (p_compare_flag) else $error("compare flag not set on match"); // R19

    property p_cnt_load;
        @(posedge i_mclk) disable iff (!i_arst_n)
            (cnt_apply && cnt_smask == 2'b11) |=> cnt_q == $past(cnt_sdata);
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("counter load value lost"); // R7

    property p_pit_irq;
        @(posedge i_mclk) disable iff (!i_arst_n) (pit_event && pit_ien_d) |=> o_periodic_tick_irq;
    endproperty
    a_pit_irq: assert property (p_pit_irq) else $error("periodic irq missing after event"); // R16 R21

    property p_pit_off_silent;
        @(posedge i_mclk) disable iff (!i_arst_n) (!pit_on || pit_code == 4'h0) |-> !pit_event;
    endproperty
    a_pit_off_silent: assert property (p_pit_off_silent) else $error("periodic event while off"); // R12 R13

    property p_irq_gated;
        @(posedge i_mclk) disable iff (!i_arst_n) !pit_ien_q |-> !o_periodic_tick_irq;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("irq not gated by enable"); // R15

    property p_bus_answer;
        @(posedge i_mclk) disable iff (!i_arst_n) (req && o_avs_waitrequest) |=> !o_avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not within one wait cycle");

    c_wrap: cover property (@(posedge i_mclk) disable iff (!i_arst_n) wrap_set);
    c_compare: cover property (@(posedge i_mclk) disable iff (!i_arst_n) cmp_set);
    c_pit_event: cover property (@(posedge i_mclk) disable iff (!i_arst_n) pit_event);
    c_cnt_load: cover property (@(posedge i_mclk) disable iff (!i_arst_n) cnt_apply);
endmodule : rtc_top
`default_nettype wire

// >>> dv/test_rtc_counter_and_periodic_timer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_rtc_counter_and_periodic_timer;
    logic        i_mclk   = 1'b0;
    logic        i_arst_n = 1'b0;
    logic [6:0]  av_addr  = 7'h00;
    logic        av_rd    = 1'b0;
    logic        av_wr    = 1'b0;
    logic [31:0] av_wd    = 32'h0;
    logic [3:0]  av_be    = 4'h0;
    logic [3:0]  ticks    = 4'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic        irq;
    int          bad_count   = 0;
    int          check_count = 0;
    int          seed        = 54578;
    logic [7:0]  exp_q[$];
    string       name_q[$];
    logic [7:0]  ex_s;
    string       nm_s;
    logic [7:0]  v;
    logic [4:0]  ridx [12] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h11, 5'h12, 5'h13};
    logic [7:0]  rrst [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    rtc_top #(.CORR_WINDOW(8192)) u_rtc_top (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(av_be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_internal_fast_tick(ticks[0]), .i_internal_slow_tick(ticks[1]),
        .i_crystal_tick(ticks[2]), .i_external_pin_tick(ticks[3]), .o_periodic_tick_irq(irq)
    );

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_mclk);
        av_addr <= {idx, 2'b00};
        av_rd   <= ~w;
        av_wr   <= w;
        av_wd   <= {24'h0, d};
        av_be   <= be;
        do begin
            @(posedge i_mclk);
            n++;
        end while (wreq && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("mismatch waitrequest expected 0 seen 1");
        end
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [4:0] idx, input logic [7:0] e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        bus(1'b0, idx, 8'h00, 4'h1);
    endtask : rd

    task automatic tk(input int src, input int n);
        repeat (n) begin
            @(posedge i_mclk);
            ticks <= 4'(1 << src);
            @(posedge i_mclk);
            ticks <= 4'h0;
        end
    endtask : tk

    task automatic rst(input int n);
        i_arst_n <= 1'b0;
        repeat (n) @(posedge i_mclk);
        i_arst_n <= 1'b1;
    endtask : rst

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Read results are judged against the oldest queued expectation
    always @(posedge i_mclk) begin
        if (av_rd && !wreq && exp_q.size() > 0) begin
            ex_s = exp_q.pop_front();
            nm_s = name_q.pop_front();
            `CHK(nm_s, rdata, {24'h0, ex_s})
        end
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        bad_count++;
        final_report();
    end

    initial begin
        rst(6);
        for (int i = 0; i < 12; i++) rd(ridx[i], rrst[i], "reset_value");
        $display("test reset values done");
        v = 8'($random(seed));
        wr(5'h06, v);
        bus(1'b1, 5'h06, ~v, 4'h0);
        rd(5'h06, v, "calibration");
        v = 8'($random(seed));
        wr(5'h0c, v);
        rd(5'h0c, v, "match_low");
        wr(5'h14, 8'h5a);
        rd(5'h14, 8'h00, "unmapped");
        $display("test register access done");
        for (int s = 0; s < 4; s++) begin
            v = 8'($random(seed));
            wr(5'h07, 8'(s));
            wr(5'h08, v);
            wr(5'h09, ~v);
            tk((s + 1) % 4, 3);
            rd(5'h01, 8'h02, "count_sync_pending");
            tk(s, 1);
            rd(5'h01, 8'h02, "count_sync_pending");
            tk(s, 1);
            rd(5'h01, 8'h00, "count_sync_pending");
            rd(5'h08, v, "count_low");
            rd(5'h09, ~v, "count_high");
            rd(5'h07, 8'(s), "source_choice");
        end
        $display("test source and count sync done");
        wr(5'h0a, 8'h03);
        wr(5'h0b, 8'h00);
        rd(5'h01, 8'h04, "wrap_sync_pending");
        wr(5'h0c, 8'h02);
        wr(5'h0d, 8'h00);
        wr(5'h08, 8'h00);
        wr(5'h09, 8'h00);
        tk(3, 2);
        rd(5'h01, 8'h00, "sync_pending");
        wr(5'h00, 8'h01);
        tk(3, 4);
        rd(5'h08, 8'h00, "count_wrapped");
        rd(5'h03, 8'h03, "wrap_and_compare_flags");
        wr(5'h03, 8'h03);
        rd(5'h03, 8'h00, "flags_cleared");
        wr(5'h00, 8'h09);
        tk(3, 4);
        rd(5'h08, 8'h02, "count_halved");
        wr(5'h00, 8'h00);
        $display("test wrap compare prescale done");
        wr(5'h12, 8'h01);
        wr(5'h10, 8'h09);
        rd(5'h11, 8'h01, "interval_sync_pending");
        tk(3, 2);
        rd(5'h11, 8'h00, "interval_sync_pending");
        tk(3, 8);
        rd(5'h13, 8'h01, "periodic_flag");
        @(negedge i_mclk);
        `CHK("periodic_irq", irq, 1'b1)
        wr(5'h12, 8'h00);
        @(negedge i_mclk);
        `CHK("periodic_irq_masked", irq, 1'b0)
        wr(5'h13, 8'h00);
        rd(5'h13, 8'h01, "periodic_flag_kept");
        for (int c = 0; c < 2; c++) begin
            wr(5'h10, (c == 0) ? 8'h79 : 8'h01);
            tk(3, 2);
            wr(5'h13, 8'h01);
            tk(3, 8);
            rd(5'h13, 8'h00, "no_periodic_event");
        end
        $display("test interval timer done");
        rst(2);
        rd(5'h0a, 8'hff, "wrap_limit_after_reset");
        wr(5'h06, 8'h01);
        wr(5'h00, 8'h05);
        tk(0, 3);
        rd(5'h08, 8'h02, "count_slow_correction");
        rst(2);
        wr(5'h00, 8'h0c);
        wr(5'h06, 8'h81);
        wr(5'h00, 8'h0d);
        tk(0, 3);
        rd(5'h08, 8'h02, "count_fast_correction");
        $display("test drift correction done");
        repeat (4) @(posedge i_mclk);
        final_report();
    end
endmodule : test_rtc_counter_and_periodic_timer
`default_nettype wire
